// File: hdl/icc_core.sv
// Operational command, cascade and acknowledge logic of the interrupt controller
module icc_core
	import icc_pkg::*;
#(
	parameter int LINES = ICC_LINES
) (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic CS_N_IN,
	input wire logic RD_N_IN,
	input wire logic WR_N_IN,
	input wire logic A0_IN,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE_OUT,
	input wire logic INTERRUPT_ACKNOWLEDGE_N_N_IN,
	input wire logic [LINES-1:0] REQ_IN,
	output logic INT_OUT,
	input wire logic [2:0] CAS_IN,
	output logic [2:0] CAS_OUT,
	output logic CAS_OE_OUT,
	output logic SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT,
	input wire logic SP_IN,
	input wire logic SINGLE_IN,
	input wire logic BUFFERED_IN,
	input wire logic BUF_MASTER_IN,
	input wire logic AUTO_EOI_IN,
	input wire logic VECTOR_MODE_IN,
	input wire logic LEVEL_TRIG_IN,
	input wire logic [7:0] CASCADE_INIT_IN,
	input wire logic [4:0] VECTOR_BASE_IN
);
	// ==========================================================
	// Input synchronisers
	logic [LINES-1:0] req_s1, req_s2, req_d;
	logic [2:0] cas_s1, cas_s2;
	logic [4:0] bus_s1, bus_s2, bus_d;
	logic [7:0] dat_s1, dat_s2;
	logic sp_s1, sp_s2;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			req_s1 <= '0;
			req_s2 <= '0;
			req_d <= '0;
			cas_s1 <= 3'h0;
			cas_s2 <= 3'h0;
			bus_s1 <= 5'h1F;
			bus_s2 <= 5'h1F;
			bus_d <= 5'h1F;
			dat_s1 <= 8'h00;
			dat_s2 <= 8'h00;
			sp_s1 <= 1'b1;
			sp_s2 <= 1'b1;
		end else begin
			req_s1 <= REQ_IN;
			req_s2 <= req_s1;
			req_d <= req_s2;
			cas_s1 <= CAS_IN;
			cas_s2 <= cas_s1;
			bus_s1 <= {CS_N_IN, RD_N_IN, WR_N_IN, INTERRUPT_ACKNOWLEDGE_N_N_IN, A0_IN};
			bus_s2 <= bus_s1;
			bus_d <= bus_s2;
			dat_s1 <= DATA_IN;
			dat_s2 <= dat_s1;
			sp_s1 <= SP_IN;
			sp_s2 <= sp_s1;
		end
	end
	logic cs_n, rd_n, wr_n, ack_n, a0;
	assign {cs_n, rd_n, wr_n, ack_n, a0} = bus_s2;
	logic wr_rise, ack_fall, ack_rise;
	assign wr_rise = !cs_n && wr_n && !bus_d[2];
	assign ack_fall = !ack_n && bus_d[1];
	assign ack_rise = ack_n && !bus_d[1];
	// Role: buffered mode takes it from the role bit, else from the pin
	logic is_master;
	assign is_master = BUFFERED_IN ? BUF_MASTER_IN : sp_s2;
	logic cascaded;
	assign cascaded = !SINGLE_IN || BUFFERED_IN;

	// ==========================================================
	// Command decode
	logic wr_mask, wr_eoi, wr_rdp;
	assign wr_mask = wr_rise && a0;
	assign wr_eoi = wr_rise && !a0 && !dat_s2[ICC_CMD_BIT4] && !dat_s2[ICC_CMD_BIT3];
	assign wr_rdp = wr_rise && !a0 && !dat_s2[ICC_CMD_BIT4] && dat_s2[ICC_CMD_BIT3];
	icc_op_t op;
	assign op = icc_op_t'({dat_s2[ICC_R_POS], dat_s2[ICC_SL_POS], dat_s2[ICC_EOI_POS]});
	logic [2:0] op_level;
	assign op_level = dat_s2[2:0];

	// ==========================================================
	// Mask, special mask, read select and poll
	logic [7:0] mask_register;
	logic special_mask, read_irr, poll;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			mask_register <= ICC_MASK_RESET;
		end else if (wr_mask) begin
			mask_register <= dat_s2;
		end
	end
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			special_mask <= 1'b0;
			read_irr <= 1'b1;
		end else if (wr_rdp) begin
			if (dat_s2[ICC_SPECIAL_MASK_ENABLE_BIT_POS]) begin
				special_mask <= dat_s2[ICC_SMM_POS];
			end
			if (dat_s2[ICC_RR_POS]) begin
				read_irr <= dat_s2[ICC_RIS_POS];
			end
		end
	end
	// Poll is a one-shot: cleared by the next read of the even address
	logic rd_rise_done;
	assign rd_rise_done = !cs_n && rd_n && !bus_d[3] && !a0;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			poll <= 1'b0;
		end else if (wr_rdp) begin
			poll <= dat_s2[ICC_POLL_POS];
		end else if (rd_rise_done) begin
			poll <= 1'b0;
		end
	end

	// ==========================================================
	// Request register
	logic [7:0] request_register, in_service_register;
	logic [2:0] lowest;
	logic rotate_auto;
	logic [7:0] edge_hit;
	logic [7:0] take_clr;
	assign edge_hit = LEVEL_TRIG_IN ? req_s2 : (req_s2 & ~req_d);
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			request_register <= 8'h00;
		end else begin
			request_register <= ((request_register & ~take_clr) | edge_hit) & req_s2;
		end
	end

	// ==========================================================
	// Priority resolution
	logic [7:0] eligible_req;
	logic [7:0] blocking_isr;
	logic req_found, isr_found;
	logic [2:0] req_level, isr_level;
	assign eligible_req = request_register & ~mask_register;
	assign blocking_isr = special_mask ? (in_service_register & ~mask_register)
		: in_service_register;
	icc_prio #(.LINES(LINES)) u_req_prio (
		.req_in(eligible_req),
		.lowest_in(lowest),
		.found_out(req_found),
		.level_out(req_level)
	);
	icc_prio #(.LINES(LINES)) u_isr_prio (
		.req_in(blocking_isr),
		.lowest_in(lowest),
		.found_out(isr_found),
		.level_out(isr_level)
	);
	// Distance below the lowest-priority slot, less one: larger value means higher priority, except the lowest slot itself ranks 7
	logic [2:0] req_rank, isr_rank;
	assign req_rank = 3'(lowest - req_level - 3'h1);
	assign isr_rank = 3'(lowest - isr_level - 3'h1);
	logic want_int;
	assign want_int = req_found && (!isr_found || req_rank > isr_rank);

	// ==========================================================
	// Acknowledge sequence
	logic [1:0] ack_count;
	logic [2:0] ack_level;
	logic ack_slave, ack_active;
	logic [1:0] ack_total;
	assign ack_total = VECTOR_MODE_IN ? ICC_ACK_VECTOR : ICC_ACK_CALL;
	logic our_slave_turn;
	assign our_slave_turn = !is_master && cascaded && cas_s2 == CASCADE_INIT_IN[2:0];
	logic last_ack;
	assign last_ack = ack_rise && ack_count == ack_total;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ack_count <= 2'h0;
			ack_level <= 3'h0;
			ack_slave <= 1'b0;
			ack_active <= 1'b0;
		end else if (ack_fall) begin
			ack_count <= 2'(ack_count + 2'h1);
			if (ack_count == 2'h0) begin
				ack_active <= 1'b1;
				ack_level <= req_level;
				ack_slave <= is_master && cascaded && CASCADE_INIT_IN[req_level];
			end
		end else if (last_ack) begin
			ack_count <= 2'h0;
			ack_active <= 1'b0;
			ack_slave <= 1'b0;
		end
	end
	assign take_clr = (ack_fall && ack_count == 2'h0 && req_found)
		? (8'h01 << req_level) : 8'h00;

	// ==========================================================
	// In-service register and rotation
	logic [7:0] isr_eoi_clr;
	always_comb begin
		isr_eoi_clr = 8'h00;
		if (wr_eoi) begin
			unique case (op)
				ICC_EOI_NONSPEC, ICC_ROT_NONSPEC: isr_eoi_clr = isr_found ? (8'h01 << isr_level) : 8'h00;
				ICC_EOI_SPEC, ICC_ROT_SPEC: isr_eoi_clr = 8'h01 << op_level;
				ICC_NOP_ROT_AUTO_CLR, ICC_NOP, ICC_ROT_AUTO_SET, ICC_SET_PRIO: isr_eoi_clr = 8'h00;
			endcase
		end
	end
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			in_service_register <= 8'h00;
		end else if (ack_fall && ack_count == 2'h0 && req_found && !AUTO_EOI_IN) begin
			in_service_register <= (in_service_register & ~isr_eoi_clr) | take_clr;
		end else begin
			// Automatic END_OF_INTERRUPT_BIT: bit is never held past the final acknowledge
			in_service_register <= in_service_register & ~isr_eoi_clr;
		end
	end
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			lowest <= ICC_PRIO_RESET;
			rotate_auto <= 1'b0;
		end else if (wr_eoi) begin
			unique case (op)
				ICC_ROT_NONSPEC: lowest <= isr_found ? isr_level : lowest;
				ICC_ROT_SPEC, ICC_SET_PRIO: lowest <= op_level;
				ICC_ROT_AUTO_SET: rotate_auto <= 1'b1;
				ICC_NOP_ROT_AUTO_CLR: rotate_auto <= 1'b0;
				ICC_EOI_NONSPEC, ICC_EOI_SPEC, ICC_NOP: lowest <= lowest;
			endcase
		end else if (last_ack && AUTO_EOI_IN && rotate_auto) begin
			lowest <= ack_level;
		end
	end

	// ==========================================================
	// Interrupt output, cascade bus and data bus
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			INT_OUT <= 1'b0;
		end else begin
			INT_OUT <= want_int && !poll && !ack_active;
		end
	end
	// Cascade lines: low unless serving a slave input, address held until last ack
	logic cas_drive;
	assign cas_drive = ack_active && ack_slave && ack_count != 2'h0;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			CAS_OUT <= 3'h0;
		end else begin
			CAS_OUT <= (is_master && cas_drive) ? ack_level : 3'h0;
		end
	end
	assign CAS_OE_OUT = is_master && cascaded;
	// Who supplies acknowledge bytes: master for peripherals and the first byte, matched slave for later bytes
	logic ack_byte_ours;
	always_comb begin
		if (is_master || !cascaded) begin
			ack_byte_ours = !ack_slave || (ack_count == 2'h1 && !ack_fall);
		end else begin
			ack_byte_ours = our_slave_turn && ack_count >= 2'h2;
		end
	end
	logic rd_active, ack_active_drive;
	assign rd_active = !cs_n && !rd_n;
	assign ack_active_drive = !ack_n && ack_byte_ours && ack_count != 2'h0;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			DATA_OUT <= 8'h00;
		end else if (rd_active) begin
			if (a0) begin
				DATA_OUT <= mask_register;
			end else if (poll) begin
				DATA_OUT <= {req_found, 4'h0, req_level};
			end else begin
				DATA_OUT <= read_irr ? request_register : in_service_register;
			end
		end else if (!ack_n) begin
			if (VECTOR_MODE_IN) begin
				DATA_OUT <= {VECTOR_BASE_IN, ack_level};
			end else if (ack_count == 2'h1 && !our_slave_turn) begin
				DATA_OUT <= ICC_CALL_OPCODE;
			end else begin
				DATA_OUT <= {VECTOR_BASE_IN, ack_level};
			end
		end
	end
	assign DATA_OE_OUT = rd_active || ack_active_drive;
	assign SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT = !(BUFFERED_IN && DATA_OE_OUT);
endmodule : icc_core

// File: hdl/icc_prio.sv
// Rotating priority resolver for eight lines
module icc_prio
	import icc_pkg::*;
#(
	parameter int LINES = ICC_LINES
) (
	input wire logic [LINES-1:0] req_in,
	input wire logic [2:0] lowest_in,
	output logic found_out,
	output logic [2:0] level_out
);
	// Scan from the level just above the lowest, wrapping around
	always_comb begin
		found_out = 1'b0;
		level_out = 3'h0;
		for (int k = LINES - 1; k >= 0; k--) begin
			if (req_in[3'(lowest_in + 3'(k + 1))]) begin
				found_out = 1'b1;
				level_out = 3'(lowest_in + 3'(k + 1));
			end
		end
	end
endmodule : icc_prio

// File: inc/icc_pkg.sv
// Package of constants and types for the interrupt command and cascade logic
//
// Functional notes
// - Each mask bit set disables its request input; clear enables it.
// - In special mask mode the mask also overrides in-service blocking.
// - Level-select bits name the acted-on level only when set-level bit is one.
// - A set-level rotate makes the named input the lowest priority.
// - Rotate bit applies priority rotation, optionally with END_OF_INTERRUPT_BIT and set-level.
// - Register-select zero reads in-service, one reads request register.
// - Read-register bit drives the selected register; selection persists.
// - Poll bit selects polling; interrupt output is then not driven.
// - Special-mask bit sets or clears special mask only when enable bit is one.
// - In buffered mode the program/enable pin enables buffers while driving data.
// - In buffered mode master or slave role comes from buffered-role bit.
// - A master serves up to eight slaves, one per request input.
// - Master holds cascade lines low except when serving a slave input.
// - Master holds slave address from first to last acknowledge trailing edge.
// - Cascade init word marks slave inputs with one, peripherals with zero.
// - For peripheral inputs the master keeps cascade low and supplies vector.
// - For winning slave input master raises interrupt and drives its number.
// - Slave compares cascade lines with its address and supplies later bytes.
// - Slave raises interrupt only with no higher-priority request pending inside.
// - Automatic END_OF_INTERRUPT_BIT sets then clears the in-service bit on final acknowledge; the code never sets it in that mode.
// - Non-specific END_OF_INTERRUPT_BIT clears the highest-priority in-service bit.
// - Specific END_OF_INTERRUPT_BIT clears the in-service bit named by level-select bits.
package icc_pkg;
	localparam int ICC_LINES = 8;
	localparam logic [7:0] ICC_MASK_RESET = 8'h00;
	localparam logic [2:0] ICC_PRIO_RESET = 3'h7;
	// Command word field positions
	localparam int ICC_CMD_BIT4 = 4;
	localparam int ICC_CMD_BIT3 = 3;
	localparam int ICC_EOI_POS = 5;
	localparam int ICC_SL_POS = 6;
	localparam int ICC_R_POS = 7;
	localparam int ICC_RIS_POS = 0;
	localparam int ICC_RR_POS = 1;
	localparam int ICC_POLL_POS = 2;
	localparam int ICC_SMM_POS = 5;
	localparam int ICC_SPECIAL_MASK_ENABLE_BIT_POS = 6;
	// Acknowledge pulses per sequence
	localparam logic [1:0] ICC_ACK_CALL = 2'h3;
	localparam logic [1:0] ICC_ACK_VECTOR = 2'h2;
	localparam logic [7:0] ICC_CALL_OPCODE = 8'hCD;
	typedef enum logic [2:0] {
		ICC_NOP_ROT_AUTO_CLR, ICC_EOI_NONSPEC, ICC_NOP, ICC_EOI_SPEC,
		ICC_ROT_AUTO_SET, ICC_ROT_NONSPEC, ICC_SET_PRIO, ICC_ROT_SPEC
	} icc_op_t;
endpackage : icc_pkg

// File: test/icc_core_props.sv
// Concurrent checks on the command and cascade ports of icc_core
module icc_core_props (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic RD_N_IN,
	input wire logic INTERRUPT_ACKNOWLEDGE_N_N_IN,
	input wire logic INT_OUT,
	input wire logic DATA_OE_OUT,
	input wire logic [2:0] CAS_OUT,
	input wire logic CAS_OE_OUT,
	input wire logic SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT,
	input wire logic SINGLE_IN,
	input wire logic BUFFERED_IN,
	input wire logic BUF_MASTER_IN,
	input wire logic [7:0] CASCADE_INIT_IN
);
	logic [3:0] quiet;
	// ======
	// Cycles since the last read or acknowledge pulse
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			quiet <= 4'hF;
		end else if (!RD_N_IN || !INTERRUPT_ACKNOWLEDGE_N_N_IN) begin
			quiet <= 4'h0;
		end else if (quiet != 4'hF) begin
			quiet <= quiet + 4'h1;
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// ======
	// Assertions
	sp_enable_a: assert property (BUFFERED_IN |-> SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT == !DATA_OE_OUT)
		else $error("buffer enable does not follow data drive");
	oe_cause_a: assert property (DATA_OE_OUT |-> quiet < 4'h8)
		else $error("data driven without read or acknowledge");
	cas_mark_a: assert property (CAS_OUT != 3'h0 |-> CASCADE_INIT_IN[CAS_OUT])
		else $error("cascade address of an unmarked input");
	cas_single_a: assert property (CAS_OE_OUT |-> !SINGLE_IN || BUFFERED_IN)
		else $error("cascade driven in single mode");
	buf_role_a: assert property (BUFFERED_IN && !BUF_MASTER_IN |-> !CAS_OE_OUT)
		else $error("buffered slave drives cascade");
	cas_start_a: assert property ($rose(CAS_OUT != 3'h0) |-> !INTERRUPT_ACKNOWLEDGE_N_N_IN)
		else $error("cascade address outside acknowledge");
	cas_hold_a: assert property ((CAS_OUT != 3'h0) ##1 (CAS_OUT != 3'h0) |-> $stable(CAS_OUT))
		else $error("cascade address changed in sequence");
	cas_drop_a: assert property (INTERRUPT_ACKNOWLEDGE_N_N_IN [*8] |-> ##[0:4] CAS_OUT == 3'h0)
		else $error("cascade lines not low when idle");
	cover property (CAS_OE_OUT && CAS_OUT == 3'h4);
	cover property ($rose(DATA_OE_OUT) && !INTERRUPT_ACKNOWLEDGE_N_N_IN);
	cover property ($rose(INT_OUT));
endmodule : icc_core_props

bind icc_core icc_core_props u_icc_core_props (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
	.RD_N_IN(RD_N_IN), .INTERRUPT_ACKNOWLEDGE_N_N_IN(INTERRUPT_ACKNOWLEDGE_N_N_IN), .INT_OUT(INT_OUT), .DATA_OE_OUT(DATA_OE_OUT),
	.CAS_OUT(CAS_OUT), .CAS_OE_OUT(CAS_OE_OUT), .SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT(SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT),
	.SINGLE_IN(SINGLE_IN), .BUFFERED_IN(BUFFERED_IN), .BUF_MASTER_IN(BUF_MASTER_IN),
	.CASCADE_INIT_IN(CASCADE_INIT_IN));

// File: test/icc_peer.sv
// Slave controller model answering on the cascade bus
module icc_peer #(
	parameter logic [2:0] SLV_ID = 3'h4,
	parameter logic [7:0] SLV_VEC = 8'h9C
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic interrupt_acknowledge_n_n_in,
	input wire logic [2:0] cas_in,
	output logic [7:0] data_out,
	output logic oe_out
);
	logic seen;
	// ======
	// Address match, then drive on the next acknowledge pulse
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			seen <= 1'b0;
		end else if (cas_in != SLV_ID) begin
			seen <= 1'b0;
		end else if (interrupt_acknowledge_n_n_in) begin
			seen <= 1'b1;
		end
	end
	assign oe_out = seen && !interrupt_acknowledge_n_n_in && cas_in == SLV_ID;
	assign data_out = oe_out ? SLV_VEC : ~SLV_VEC;
endmodule : icc_peer

// File: test/test_icc_core.sv
// Testbench for the command and cascade logic
module test_icc_core
	import icc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] SV = 8'h9C;
	logic clk, rstn, cs_n, rd_n, wr_n, interrupt_acknowledge_n_n, a0, bm, sp, oe, cas_oe, int_o, slave_program_buffer_enable_n, p_oe;
	logic vm, auto_eoi_bit;
	logic [7:0] wd, ci, bus, dout, p_d, b;
	logic [ICC_LINES-1:0] req;
	logic [4:0] vb;
	logic [2:0] cas_o, cas_d, cas_w, c;
	int err_total, tests_run;
	always #2.5 clk = ~clk;
	assign cas_w = cas_oe ? cas_o : cas_d;
	always_comb begin
		if (oe && p_oe) begin
			bus = 8'hXX;
		end else if (oe) begin
			bus = dout;
		end else if (p_oe) begin
			bus = p_d;
		end else begin
			bus = wd;
		end
	end
	icc_core u_icc_core (.CLK_IN(clk), .RSTN_IN(rstn), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
		.WR_N_IN(wr_n), .A0_IN(a0), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_OUT(oe),
		.INTERRUPT_ACKNOWLEDGE_N_N_IN(interrupt_acknowledge_n_n), .REQ_IN(req), .INT_OUT(int_o), .CAS_IN(cas_w), .CAS_OUT(cas_o),
		.CAS_OE_OUT(cas_oe), .SLAVE_PROGRAM_BUFFER_ENABLE_N_OUT(slave_program_buffer_enable_n), .SP_IN(sp), .SINGLE_IN(1'b0),
		.BUFFERED_IN(1'b1), .BUF_MASTER_IN(bm), .AUTO_EOI_IN(auto_eoi_bit), .VECTOR_MODE_IN(vm),
		.LEVEL_TRIG_IN(1'b0), .CASCADE_INIT_IN(ci), .VECTOR_BASE_IN(vb));
	icc_peer #(.SLV_VEC(SV)) u_icc_peer (.clk_in(clk), .rstn_in(rstn), .interrupt_acknowledge_n_n_in(interrupt_acknowledge_n_n),
		.cas_in(cas_w), .data_out(p_d), .oe_out(p_oe));
	// ======
	// Bus tasks
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic a, input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		a0 <= a;
		wd <= d;
		wr_n <= 1'b0;
		cyc(6);
		wr_n <= 1'b1;
		cyc(2);
		cs_n <= 1'b1;
		cyc(4);
	endtask : wr
	task rd(input logic a, input logic [7:0] e);
		@(posedge clk);
		cs_n <= 1'b0;
		a0 <= a;
		rd_n <= 1'b0;
		cyc(6);
		chk(dout, e);
		rd_n <= 1'b1;
		cyc(2);
		cs_n <= 1'b1;
		cyc(4);
	endtask : rd
	task irq(input logic e);
		cyc(12);
		chk({7'h00, int_o}, {7'h00, e});
	endtask : irq
	task ack(input logic [2:0] ec, input logic [7:0] eb);
		repeat (vm ? 2 : 3) begin
			@(posedge clk);
			interrupt_acknowledge_n_n <= 1'b0;
			cyc(6);
			b = bus;
			c = cas_w;
			interrupt_acknowledge_n_n <= 1'b1;
			cyc(4);
		end
		chk(b, eb);
		chk({5'h00, c}, {5'h00, ec});
		cyc(6);
	endtask : ack
	task finish_test;
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	// ======
	// Watchdog
	initial begin
		cyc(6000);
		err_total++;
		$display("CHECK FAILED at %0t: timeout", $time);
		finish_test();
	end
	// ======
	// Tests
	initial begin
		{clk, rstn, a0, auto_eoi_bit, req, cas_d, wd, err_total, tests_run} = '0;
		{cs_n, rd_n, wr_n, interrupt_acknowledge_n_n, bm, sp, vm} = 7'h7F;
		ci = 8'h10;
		vb = 5'h15;
		cyc(16);
		rstn <= 1'b1;
		cyc(4);
		wr(1'b1, 8'hFE);
		rd(1'b1, 8'hFE);
		req <= 8'h02;
		irq(1'b0);
		wr(1'b0, 8'h0B);
		rd(1'b0, 8'h02);
		rd(1'b0, 8'h02);
		wr(1'b1, 8'h00);
		irq(1'b1);
		ack(3'h0, {vb, 3'h1});
		wr(1'b0, 8'h0A);
		rd(1'b0, 8'h02);
		wr(1'b0, 8'h61);
		rd(1'b0, 8'h00);
		$display("mask and read test done");
		req <= 8'h08;
		irq(1'b1);
		ack(3'h0, {vb, 3'h3});
		req <= 8'h0A;
		irq(1'b1);
		ack(3'h0, {vb, 3'h1});
		wr(1'b0, 8'h43);
		rd(1'b0, 8'h0A);
		wr(1'b0, 8'h20);
		rd(1'b0, 8'h08);
		wr(1'b0, 8'hA0);
		rd(1'b0, 8'h00);
		$display("eoi test done");
		req <= 8'h00;
		wr(1'b0, 8'hC1);
		req <= 8'h06;
		irq(1'b1);
		ack(3'h0, {vb, 3'h2});
		req <= 8'h0E;
		irq(1'b0);
		wr(1'b0, 8'h28);
		irq(1'b0);
		wr(1'b1, 8'h04);
		wr(1'b0, 8'h68);
		irq(1'b1);
		ack(3'h0, {vb, 3'h3});
		ack(3'h0, {vb, 3'h1});
		wr(1'b0, 8'h48);
		wr(1'b0, 8'h63);
		wr(1'b0, 8'h61);
		wr(1'b0, 8'h62);
		wr(1'b1, 8'h00);
		rd(1'b0, 8'h00);
		$display("rotation and special mask test done");
		req <= 8'h00;
		cyc(2);
		req <= 8'h10;
		irq(1'b1);
		ack(3'h4, SV);
		chk({5'h00, cas_w}, 8'h00);
		wr(1'b0, 8'h20);
		rd(1'b0, 8'h00);
		$display("cascade master test done");
		req <= 8'h00;
		rstn <= 1'b0;
		bm <= 1'b0;
		vm <= 1'b0;
		auto_eoi_bit <= 1'b1;
		ci <= 8'h05;
		cas_d <= 3'h5;
		cyc(4);
		rstn <= 1'b1;
		cyc(4);
		wr(1'b0, 8'h80);
		req <= 8'h01;
		irq(1'b1);
		ack(3'h5, {vb, 3'h0});
		wr(1'b0, 8'h0A);
		rd(1'b0, 8'h00);
		req <= 8'h00;
		cyc(2);
		req <= 8'h03;
		irq(1'b1);
		ack(3'h5, {vb, 3'h1});
		wr(1'b0, 8'h0C);
		irq(1'b0);
		rd(1'b0, 8'h80);
		$display("cascade slave test done");
		finish_test();
	end
endmodule : test_icc_core
